// ### hss_regs.svh
// Timing constants and head map fields for head select and squelch control
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH
`define HSS_CLK_PERIOD_NS 10
`define HSS_SQUELCH_HOLD_NS 5000
`define HSS_SQUELCH_CYCLES (`HSS_SQUELCH_HOLD_NS / `HSS_CLK_PERIOD_NS)
`define HSS_UNSAFE_SETTLE_NS 1000
`define HSS_UNSAFE_CYCLES ((`HSS_UNSAFE_SETTLE_NS + `HSS_CLK_PERIOD_NS - 1) / `HSS_CLK_PERIOD_NS)
`define HSS_CS_NONE 3'h7
`define HSS_HEAD_UNMAPPED 4'hf
`endif

// ### hss_pkg.sv
// Types for head select and squelch control
package hss_pkg;
    typedef logic [3:0] hss_head_t;
    typedef logic [5:0] hss_map_t;
    typedef enum logic [1:0] {HSS_IDLE, HSS_WAIT, HSS_SAFE} hss_wstate_t;
endpackage

// ### hss_head_map.sv
// Combinational head number to preamp select and head line map
`timescale 1ns/1ns
`default_nettype none
`include "hss_regs.svh"
module hss_head_map
    import hss_pkg::*;
(
    input wire hss_pkg::hss_head_t head, // Binary head number
    output logic [2:0] cs_n,             // Preamp selects, active low
    output logic [2:0] hs                // Head line bits
);
    hss_map_t map;
    always_comb
    begin
        case (head)
            4'h0: map = 6'b101_100;
            4'h1: map = 6'b101_101;
            4'h2: map = 6'b011_000;
            4'h3: map = 6'b011_001;
            4'h4: map = 6'b011_010;
            4'h5: map = 6'b011_011;
            4'h6: map = 6'b011_100;
            4'h7: map = 6'b011_101;
            4'h8: map = 6'b101_011;
            4'h9: map = 6'b101_010;
            4'ha: map = 6'b101_001;
            4'hb: map = 6'b101_000;
            4'hc: map = 6'b110_101;
            4'hd: map = 6'b110_100;
            4'he: map = 6'b110_011;
            default: map = {`HSS_CS_NONE, 3'h0};
        endcase
    end
    assign cs_n = map[5:3];
    assign hs = map[2:0];
endmodule
`default_nettype wire

// ### hss_ctrl.sv
// Head select decode, squelch timing and write-unsafe qualification
`timescale 1ns/1ns
`default_nettype none
`include "hss_regs.svh"
module hss_ctrl
    import hss_pkg::*;
#(
    parameter int SQUELCH_CYCLES = `HSS_SQUELCH_CYCLES,
    parameter int UNSAFE_CYCLES = `HSS_UNSAFE_CYCLES
)
(
    input wire logic clk,                  // 100 MHz clock
    input wire logic rst,                  // Sync reset, active high
    input wire logic [3:0] head_select_n,  // Host head number, active low
    input wire logic write_cmd,            // Internal write command
    input wire logic write_bit,            // Encoded write transition request
    input wire logic write_unsafe_flag,    // Preamp unsafe, high = unsafe
    output logic preamp_select_low,        // Preamp select 0, active low
    output logic preamp_select_mid,        // Preamp select 1, active low
    output logic preamp_select_high,       // Preamp select 2, active low
    output logic head_line_bit0,           // Head line bit 0
    output logic head_line_bit1,           // Head line bit 1
    output logic head_line_bit2,           // Head line bit 2
    output logic squelch_n,                // Pulse detector squelch, low
    output logic write_data_drive,         // Write data to preamp
    output logic write_safe,               // Write confirmed safe
    output logic write_fault               // Unsafe seen during safe write
);
    import hss_pkg::*;
    localparam int CW = $clog2(SQUELCH_CYCLES + 1);
    localparam int WW = $clog2(UNSAFE_CYCLES + 1);
    localparam logic [CW-1:0] SQ_LOAD = CW'(SQUELCH_CYCLES);
    localparam logic [WW-1:0] UNSAFE_LOAD = WW'(UNSAFE_CYCLES);

    hss_head_t head_num;
    hss_head_t head_q;
    logic [2:0] cs_n_w;
    logic [2:0] hs_w;
    logic [2:0] cs_q;
    logic [2:0] hs_q;
    logic [CW-1:0] sq_cnt_q;
    logic [WW-1:0] unsafe_cnt_q;
    logic write_q;
    logic wd_q;
    logic head_switch;
    logic write_fall;
    logic sq_active;
    hss_wstate_t wst_q;
    hss_wstate_t wst_d;

    assign head_num = ~head_select_n;

    hss_head_map u_map (
        .head(head_num),
        .cs_n(cs_n_w),
        .hs(hs_w)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cs_q <= `HSS_CS_NONE;
            hs_q <= 3'h0;
            head_q <= `HSS_HEAD_UNMAPPED;
        end
        else
        begin
            cs_q <= cs_n_w;
            hs_q <= hs_w;
            head_q <= head_num;
        end
    end

    assign preamp_select_low = cs_q[0];
    assign preamp_select_mid = cs_q[1];
    assign preamp_select_high = cs_q[2];
    assign head_line_bit0 = hs_q[0];
    assign head_line_bit1 = hs_q[1];
    assign head_line_bit2 = hs_q[2];

    // any head change is a switch
    assign head_switch = head_num != head_q;
    assign write_fall = write_q && !write_cmd;

    always_ff @(posedge clk)
    begin
        if (rst)
            sq_cnt_q <= '0;
        else if (head_switch || write_fall)
            sq_cnt_q <= SQ_LOAD;
        else if (sq_cnt_q != '0)
            sq_cnt_q <= sq_cnt_q - CW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            write_q <= 1'b0;
        else
            write_q <= write_cmd;
    end

    assign sq_active = write_q || (sq_cnt_q != '0);
    assign squelch_n = !sq_active;

    // preamp toggle halves edges, so each request while write_cmd is high toggles the line
    always_ff @(posedge clk)
    begin
        if (rst)
            wd_q <= 1'b1;
        else if (write_cmd && write_bit)
            wd_q <= !wd_q;
    end
    assign write_data_drive = wd_q;

    // ignore unsafe flag until settle time
    always_comb
    begin
        wst_d = wst_q;
        case (wst_q)
            HSS_IDLE: if (write_cmd) wst_d = HSS_WAIT;
            HSS_WAIT:
                if (!write_cmd) wst_d = HSS_IDLE;
                else if (unsafe_cnt_q == '0 && !write_unsafe_flag)
                    wst_d = HSS_SAFE;
            HSS_SAFE: if (!write_cmd) wst_d = HSS_IDLE;
            default: wst_d = HSS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wst_q <= HSS_IDLE;
            unsafe_cnt_q <= UNSAFE_LOAD;
        end
        else
        begin
            wst_q <= wst_d;
            if (wst_q == HSS_IDLE)
                unsafe_cnt_q <= UNSAFE_LOAD;
            else if (unsafe_cnt_q != '0)
                unsafe_cnt_q <= unsafe_cnt_q - WW'(1);
        end
    end

    // unsafe in a safe write is a fault
    always_ff @(posedge clk)
    begin
        if (rst)
            write_fault <= 1'b0;
        else
            write_fault <= (wst_q == HSS_SAFE) && write_cmd
                && write_unsafe_flag;
    end
    assign write_safe = (wst_q == HSS_SAFE);

    sequence s_write_end;
        write_q && !write_cmd;
    endsequence

    a_squelch_in_write:
    assert property (@(posedge clk) disable iff (rst)
        write_cmd |=> !squelch_n)
    else $error("squelch released during write");

    a_squelch_hold_after:
    assert property (@(posedge clk) disable iff (rst)
        s_write_end ##1 (!write_q && !head_switch) [*8] |-> !squelch_n)
    else $error("squelch dropped early after write");

    a_squelch_head_sw:
    assert property (@(posedge clk) disable iff (rst)
        head_switch |=> sq_cnt_q == SQ_LOAD && !squelch_n)
    else $error("head switch did not load squelch");

    a_squelch_restart:
    assert property (@(posedge clk) disable iff (rst)
        (sq_cnt_q != '0 && head_switch) |=> sq_cnt_q == SQ_LOAD)
    else $error("squelch interval not restarted");

    a_cs_one_hot:
    assert property (@(posedge clk) disable iff (rst)
        head_num != `HSS_HEAD_UNMAPPED |=> $countones(~cs_q) == 1)
    else $error("not exactly one preamp selected");

    a_cs_unmapped:
    assert property (@(posedge clk) disable iff (rst)
        head_num == `HSS_HEAD_UNMAPPED |=> cs_q == `HSS_CS_NONE)
    else $error("selects active for head fifteen");

    a_map_head0:
    assert property (@(posedge clk) disable iff (rst)
        head_num == 4'h0 |=> cs_q == 3'b101 && hs_q == 3'b100)
    else $error("head zero map wrong");

    a_safe_settle:
    assert property (@(posedge clk) disable iff (rst)
        $rose(write_cmd) && wst_q == HSS_IDLE |=> !write_safe [*2])
    else $error("write safe before settle time");

    a_wd_toggle:
    assert property (@(posedge clk) disable iff (rst)
        write_cmd && write_bit |=> write_data_drive != $past(write_data_drive))
    else $error("write data did not toggle");

    a_fault_flag:
    assert property (@(posedge clk) disable iff (rst)
        write_safe && write_cmd && write_unsafe_flag |=> write_fault)
    else $error("unsafe not reported");
endmodule
`default_nettype wire

// ### hss_preamp_model.sv
// Behavioural preamp model that drives the write-unsafe flag
`timescale 1ns/1ns
`default_nettype none
module hss_preamp_model
#(
    parameter int SETTLE = 2,
    parameter int GAP = 16
)
(
    input wire logic clk,          // Drive clock
    input wire logic [2:0] cs_n,   // Chip selects, active low
    input wire logic write_gate,   // Write mode request
    input wire logic wr_data,      // Write data line
    output logic write_unsafe_flag // High means unsafe
);
    logic prev_q = 1'h1;
    int settle_q = 0;
    int gap_q = 0;
    always_ff @(posedge clk)
    begin
        prev_q <= wr_data;
        // only falling edges flip the write current
        gap_q <= (prev_q && !wr_data) ? 0 : gap_q + 1;
        settle_q <= write_gate ? settle_q + 1 : 0;
    end
    // unsafe unless writing, selected, settled and edges fresh
    assign write_unsafe_flag = !(write_gate && cs_n != 3'h7 &&
        settle_q >= SETTLE && gap_q < GAP);
endmodule

// Pulse qualifier model: one pulse when amplitude state changed
module hss_pulse_model
(
    input wire logic clk,                // Drive clock
    input wire logic peak_clk,           // Peak timing strobe
    input wire logic amp_qual,           // Amplitude qualification level
    output logic qualified_peak_pulse    // One pulse per peak strobe seeing a changed qualifier
);
    logic last_q = 1'h0;
    logic pulse_q = 1'h0;
    always_ff @(posedge clk)
    begin
        if (peak_clk)
            last_q <= amp_qual;
        pulse_q <= peak_clk && (amp_qual != last_q);
    end
    assign qualified_peak_pulse = pulse_q;
endmodule
`default_nettype wire

// ### hss_ctrl_tb_top.sv
// Self-checking bench for head select and squelch control
`timescale 1ns/1ns
`default_nettype none
module hss_ctrl_tb_top;
    import hss_pkg::*;
    localparam int SQ = 8;
    localparam int WU = 4;
    localparam logic [5:0] MAP [16] = '{6'h2c, 6'h2d, 6'h18, 6'h19, 6'h1a,
        6'h1b, 6'h1c, 6'h1d, 6'h2b, 6'h2a, 6'h29, 6'h28, 6'h35, 6'h34,
        6'h33, 6'h38};
    logic clk = 1'h0;
    logic rst = 1'h1;
    hss_head_t head = 4'hf;
    logic write_cmd = 1'h0;
    logic write_bit = 1'h0;
    logic starve = 1'h0;
    logic flag, cs_l, cs_m, cs_h, hl0, hl1, hl2, sq_n, wdd, safe, fault;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] rnd = 32'h0000_9cb5;
    int tmr = 0;
    int wcnt = 0;
    logic wq = 1'h0;
    logic wdd_m = 1'h1;
    hss_head_t hq = 4'hf;
    logic peak = 1'h0;
    logic amp = 1'h0;
    logic pk;
    logic pk_m = 1'h0;
    logic amp_m = 1'h0;
    logic flt_ok = 1'h0;
    always #5 clk = ~clk;
    // Head number goes out inverted: the host lines are active low
    hss_ctrl #(.SQUELCH_CYCLES(SQ), .UNSAFE_CYCLES(WU)) dut (
        .clk(clk), .rst(rst), .head_select_n(~head), .write_cmd(write_cmd),
        .write_bit(write_bit), .write_unsafe_flag(flag),
        .preamp_select_low(cs_l), .preamp_select_mid(cs_m),
        .preamp_select_high(cs_h), .head_line_bit0(hl0),
        .head_line_bit1(hl1), .head_line_bit2(hl2), .squelch_n(sq_n),
        .write_data_drive(wdd), .write_safe(safe), .write_fault(fault));
    hss_preamp_model #(.SETTLE(2), .GAP(16)) pre (.clk(clk),
        .cs_n({cs_h, cs_m, cs_l}), .write_gate(write_cmd), .wr_data(wdd),
        .write_unsafe_flag(flag));
    hss_pulse_model qual (.clk(clk), .peak_clk(peak), .amp_qual(amp),
        .qualified_peak_pulse(pk));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [5:0] e,
        input logic [5:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {5'h00, e}, {5'h00, g});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n)
        begin
            @(negedge clk);
            rnd = lfsr(rnd);
            write_bit = !starve & (rnd[0] | rnd[1]);
            peak = rnd[2];
            amp = rnd[3];
        end
    endtask
    task automatic wait_hi(input string nm, input bit for_fault);
        int i;
        logic s;
        s = for_fault ? fault : safe;
        for (i = 0; i < 64 && s !== 1'h1; i++)
        begin
            cycles(1);
            s = for_fault ? fault : safe;
        end
        chk_bit(nm, 1'h1, s);
        if (s !== 1'h1)
            complete_run();
    endtask
    // Reference model, updated on the sampling edge
    always @(posedge clk)
    begin
        pk_m = peak && (amp != amp_m);
        if (peak)
            amp_m = amp;
        if (rst)
        begin
            tmr = 0;
            wq = 1'h0;
            wdd_m = 1'h1;
            hq = 4'hf;
            wcnt = 0;
            flt_ok = 1'h0;
        end
        else
        begin
            if (head != hq || (wq && !write_cmd))
                tmr = SQ;
            else if (tmr > 0)
                tmr = tmr - 1;
            if (write_cmd && write_bit)
                wdd_m = !wdd_m;
            wcnt = write_cmd ? wcnt + 1 : 0;
            // A fault can only follow unsafe seen during a write
            flt_ok = write_cmd && flag;
            wq = write_cmd;
            hq = head;
        end
    end
    always @(negedge clk)
    begin
        chk("head map", MAP[hq], {cs_h, cs_m, cs_l, hl2, hl1, hl0});
        chk_bit("squelch_n", !(wq || tmr > 0), sq_n);
        chk_bit("write_data_drive", wdd_m, wdd);
        chk_bit("qualified_peak_pulse", pk_m, pk);
        if (!flt_ok)
            chk_bit("write_fault", 1'h0, fault);
        if (!wq)
            chk_bit("write_safe", 1'h0, safe);
        if (safe === 1'h1 && wcnt < WU + 2)
            chk_bit("early write_safe", 1'h0, safe);
    end
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        for (int h = 0; h < 16; h++)
        begin
            head = h[3:0];
            cycles(SQ + 3);
        end
        $display("test head map done");
        // Switches closer than the squelch interval must restart it
        repeat (12)
        begin
            head = rnd[7:4];
            cycles(3);
        end
        cycles(SQ + 2);
        $display("test head switch done");
        // Mid-run reset with a live head number: release is a head switch
        rst = 1'h1;
        cycles(2);
        rst = 1'h0;
        head = 4'h3;
        cycles(SQ + 2);
        $display("test reset done");
        write_cmd = 1'h1;
        wait_hi("write_safe", 1'b0);
        cycles(20);
        write_cmd = 1'h0;
        cycles(SQ + 4);
        $display("test write done");
        write_cmd = 1'h1;
        wait_hi("write_safe", 1'b0);
        starve = 1'h1;
        wait_hi("write_fault", 1'b1);
        write_cmd = 1'h0;
        starve = 1'h0;
        cycles(SQ + 4);
        $display("test write fault done");
        complete_run();
    end
endmodule
`default_nettype wire
